/* File: rtl/ops_buf.sv */
// Two-entry buffer in front of the output port
`timescale 1ns/10ps
`default_nettype none
module ops_buf #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	input  wire  logic         mclk,
	input  wire  logic         rst_n,
	input  wire  logic         ce,
	input  wire  logic [W-1:0] in_data,
	input  wire  logic         in_valid,
	output logic               in_ready,
	output logic [W-1:0]       out_data,
	output logic               out_valid,
	input  wire  logic         out_ready
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [W-1:0] mem_r [DEPTH];
	logic         wr_r;
	logic         rd_r;
	logic [1:0]   cnt_r;
	logic [1:0]   cnt_nxt;
	logic         push;
	logic         pop;

	if (DEPTH != 2 || W < 1) begin : g_bad_depth
		$error("ops_buf serves exactly two entries");
	end

	assign push     = in_valid && in_ready && ce;
	assign pop      = out_valid && out_ready && ce;
	assign out_data = mem_r[rd_r];

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always_ff @(posedge mclk) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	// Flags registered so the source sees a clean ready
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			cnt_r     <= 2'h0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push)
				wr_r <= ~wr_r;
			if (pop)
				rd_r <= ~rd_r;
			cnt_r     <= cnt_nxt;
			in_ready  <= (cnt_nxt != 2'h2);
			out_valid <= (cnt_nxt != 2'h0);
		end
	end
endmodule : ops_buf
`default_nettype wire

/* File: rtl/ops_defs.svh */
// Constants for the conversion-result output port
`ifndef OPS_DEFS_SVH
`define OPS_DEFS_SVH
`define OPS_WORD_W       16
`define OPS_CLK_NS       10
`define OPS_SCLK_P0_NS   30
`define OPS_SCLK_P1_NS   60
`define OPS_SCLK_P2_NS   120
`define OPS_SCLK_P3_NS   240
`define OPS_PIN_DIV_LO   2
`define OPS_PIN_DIV_HI   3
`define OPS_PIN_SRC      4
`define OPS_PIN_HIZ_LO   5
`define OPS_BUF_DEPTH    2
`define OPS_OE_RST       16'hFFFF
`endif

/* File: rtl/ops_pkg.sv */
// Types for the conversion-result output port
`default_nettype none
package ops_pkg;
	typedef enum logic [1:0] {
		S_IDLE,
		S_LOW,
		S_HIGH,
		S_SLAVE
	} ops_state_t;
	typedef logic [1:0] ops_div_t;
endpackage : ops_pkg
`default_nettype wire

/* File: rtl/ops_port.sv */
// Mode selection and formatting of the conversion-result output port
`timescale 1ns/10ps
`default_nettype none
`include "ops_defs.svh"
module ops_port
	import ops_pkg::*;
#(
	parameter int W = `OPS_WORD_W
) (
	input  wire  logic         mclk,
	input  wire  logic         rst_n,
	input  wire  logic         ce,
	input  wire  logic         byte_order_select,
	input  wire  logic         output_code_format_select,
	input  wire  logic         serial_parallel_select,
	input  wire  logic         read_during_convert_select,
	input  wire  logic         convert_busy,
	input  wire  logic [W-1:0] result_data,
	input  wire  logic         result_valid,
	output logic               result_ready,
	input  wire  logic [W-1:0] data_bus_i,
	output logic [W-1:0]       data_bus_o,
	output logic [W-1:0]       data_bus_oe,
	input  wire  logic         cs_n,
	input  wire  logic         serial_data_clock_i,
	output logic               serial_data_clock_o,
	output logic               serial_data_clock_oe,
	output logic               serial_data_out,
	output logic               serial_data_out_oe
);
	localparam int BW = $clog2(W);
	localparam int P0 = (`OPS_SCLK_P0_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS;
	localparam int P1 = (`OPS_SCLK_P1_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS;
	localparam int P2 = (`OPS_SCLK_P2_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS;
	localparam int P3 = (`OPS_SCLK_P3_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS;

	if (W != 16) begin : g_bad_width
		$error("ops_port serves a 16-bit result only");
	end

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_r;
	logic rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_r   <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	// ----------------------------------------
	// Buffer and mode decode
	// ----------------------------------------
	logic [W-1:0] buf_data;
	logic         buf_valid;
	logic         buf_pop;
	ops_state_t   state_r;
	logic         ser;
	logic         slave;
	logic         master;
	logic         rac;
	logic         start_ok;
	ops_div_t     div_sel;

	ops_buf #(.W(W), .DEPTH(`OPS_BUF_DEPTH)) u_buf (
		.mclk      (mclk),
		.rst_n     (rst_sync_n),
		.ce        (ce),
		.in_data   (result_data),
		.in_valid  (result_valid),
		.in_ready  (result_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (buf_pop)
	);

	assign ser    = serial_parallel_select;
	assign slave  = ser && data_bus_i[`OPS_PIN_SRC];
	assign master = ser && !data_bus_i[`OPS_PIN_SRC];
	assign rac    = master && !read_during_convert_select;
	assign start_ok = !cs_n && (slave || !rac || !convert_busy);
	assign buf_pop  = !ser || (state_r == S_IDLE && start_ok);
	assign div_sel = rac ? {data_bus_i[`OPS_PIN_DIV_HI],
		data_bus_i[`OPS_PIN_DIV_LO]} : 2'h0;

	function automatic logic [W-1:0] fmt(input logic [W-1:0] w,
		input logic bin);
		fmt = {bin ? w[W-1] : ~w[W-1], w[W-2:0]};
	endfunction : fmt

	// ----------------------------------------
	// Serial clock phase lengths
	// ----------------------------------------
	logic [5:0] per_cyc;
	logic [5:0] hi_cyc;
	logic [5:0] lo_cyc;

	// Period rounded up to whole cycles
	always_comb begin
		case (div_sel)
			2'h0:    per_cyc = 6'(P0);
			2'h1:    per_cyc = 6'(P1);
			2'h2:    per_cyc = 6'(P2);
			default: per_cyc = 6'(P3);
		endcase
		hi_cyc = (per_cyc + 6'h01) >> 1;
		lo_cyc = per_cyc - hi_cyc;
	end

	// ----------------------------------------
	// Parallel bus
	// ----------------------------------------
	logic [W-1:0] hold_r;
	logic [W-1:0] pw;
	logic [W-1:0] d_o_r;
	logic [W-1:0] d_oe_r;

	assign pw = fmt(hold_r, output_code_format_select);

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			hold_r <= '0;
		else if (ce && buf_valid && buf_pop)
			hold_r <= buf_data;
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			d_o_r <= '0;
		else if (ce) begin
			if (ser)
				d_o_r <= {{(W-2){1'b0}}, pw[1:0]};
			else if (byte_order_select)
				d_o_r <= {pw[7:0], pw[15:8]};
			else
				d_o_r <= pw;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n)
			d_oe_r <= `OPS_OE_RST;
		else if (ce) begin
			d_oe_r <= ser ? {{(W-2){1'b0}}, 2'h3} : {W{1'b1}};
		end
	end

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [W-1:0]  sh_r;
	logic [BW-1:0] bit_r;
	logic [5:0]    ph_r;
	logic          sclk_o_r;
	logic          sclk_oe_r;
	logic          sdo_r;
	logic          sdo_oe_r;
	logic          sclk_prev_r;
	logic          ext_rise;

	// Pin is taken as synchronous; previous sample finds the edge
	assign ext_rise = serial_data_clock_i && !sclk_prev_r;

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r     <= S_IDLE;
			sh_r        <= '0;
			bit_r       <= '0;
			ph_r        <= 6'h00;
			sclk_o_r    <= 1'b0;
			sdo_r       <= 1'b0;
			sclk_prev_r <= 1'b0;
		end else if (ce) begin
			sclk_prev_r <= serial_data_clock_i;
			case (state_r)
				S_IDLE: begin
					sclk_o_r <= 1'b0;
					if (ser && buf_valid && start_ok) begin
						sh_r  <= fmt(buf_data, output_code_format_select);
						sdo_r <= output_code_format_select ?
							buf_data[W-1] : ~buf_data[W-1];
						bit_r <= BW'(W-1);
						ph_r  <= lo_cyc;
						state_r <= slave ? S_SLAVE : S_LOW;
					end
				end
				// Own clock, data changes on the falling edge
				S_LOW: begin
					if (cs_n)
						state_r <= S_IDLE;
					else if (ph_r <= 6'h01) begin
						sclk_o_r <= 1'b1;
						ph_r     <= hi_cyc;
						state_r  <= S_HIGH;
					end else
						ph_r <= ph_r - 6'h01;
				end
				S_HIGH: begin
					if (cs_n) begin
						sclk_o_r <= 1'b0;
						state_r  <= S_IDLE;
					end else if (ph_r <= 6'h01) begin
						sclk_o_r <= 1'b0;
						if (bit_r == '0)
							state_r <= S_IDLE;
						else begin
							sh_r    <= sh_r << 1;
							sdo_r   <= sh_r[W-2];
							bit_r   <= bit_r - BW'(1);
							ph_r    <= lo_cyc;
							state_r <= S_LOW;
						end
					end else
						ph_r <= ph_r - 6'h01;
				end
				// Host clock, gated by chip select
				S_SLAVE: begin
					if (cs_n)
						state_r <= S_IDLE;
					else if (ext_rise) begin
						if (bit_r == '0)
							state_r <= S_IDLE;
						else begin
							sh_r  <= sh_r << 1;
							sdo_r <= sh_r[W-2];
							bit_r <= bit_r - BW'(1);
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sclk_oe_r <= 1'b0;
			sdo_oe_r  <= 1'b0;
		end else if (ce) begin
			// Clock pin driven only as master
			sclk_oe_r <= master && !cs_n;
			sdo_oe_r  <= ser && !cs_n;
		end
	end

	assign data_bus_o           = d_o_r;
	assign data_bus_oe          = d_oe_r;
	assign serial_data_clock_o  = sclk_o_r;
	assign serial_data_clock_oe = sclk_oe_r;
	assign serial_data_out      = sdo_r;
	assign serial_data_out_oe   = sdo_oe_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence hi_2_s;
		sclk_o_r [*2] ##1 !sclk_o_r;
	endsequence
	sequence hi_3_s;
		sclk_o_r [*3] ##1 !sclk_o_r;
	endsequence

	byte_swap_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(!ser && byte_order_select) |=>
		d_o_r[15:8] == $past(hold_r[7:0]) &&
		d_o_r[6:0] == $past(hold_r[14:8]))
		else $error("swapped bytes wrong");
	byte_norm_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(!ser && !byte_order_select) |=>
		d_o_r[7:0] == $past(hold_r[7:0]) &&
		d_o_r[14:8] == $past(hold_r[14:8]))
		else $error("natural bytes wrong");
	code_bin_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(!ser && !byte_order_select && output_code_format_select) |=>
		d_o_r[15] == $past(hold_r[15]))
		else $error("binary MSB altered");
	code_twos_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(!ser && !byte_order_select && !output_code_format_select) |=>
		d_o_r[15] != $past(hold_r[15]))
		else $error("twos MSB not inverted");
	par_drive_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		!ser |=> (&d_oe_r))
		else $error("parallel bus not driven");
	ser_hiz_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		ser |=> d_oe_r[W-1:`OPS_PIN_HIZ_LO] == '0)
		else $error("upper pins driven in serial");
	low_pins_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n)
		d_oe_r[1:0] == 2'h3)
		else $error("low pins released");
	div_hiz_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		ser |=> d_oe_r[3:2] == 2'h0 && !d_oe_r[4])
		else $error("serial input pins driven");
	mst_clock_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(master && !cs_n) |=> serial_data_clock_oe)
		else $error("master clock not driven");
	slv_clock_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		slave |=> !serial_data_clock_oe && state_r != S_LOW)
		else $error("slave drives clock");
	sclk_fast_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce || cs_n)
		($rose(sclk_o_r) && $past(div_sel) == 2'h0) |-> hi_2_s)
		else $error("fast clock high phase wrong");
	sclk_div_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce || cs_n)
		($rose(sclk_o_r) && $past(div_sel) == 2'h1) |-> hi_3_s)
		else $error("divided clock high phase wrong");
	rac_wait_a: assert property (@(posedge mclk)
		disable iff (!rst_sync_n || !ce)
		(state_r == S_IDLE && rac && convert_busy) |=> state_r == S_IDLE)
		else $error("read started during conversion");
endmodule : ops_port
`default_nettype wire

/* File: testbench/adc_output_port_mode_select_test.sv */
// Self-checking bench for the result output port
`timescale 1ns/10ps
`default_nettype none
module adc_output_port_mode_select_test;
	import ops_pkg::*;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        bo, fmt, sp, rdsel, busy, rv, rr, cs_n, ce;
	logic        sclk, sclk_h, sclk_o, sclk_oe, sdo, sdo_oe, sdo_w;
	logic [2:0]  cfg;
	logic [4:0]  nb;
	logic [15:0] rd, dbi, dbo, dboe, rx, per;
	logic [15:0] exp_q[$];
	int          num_errors = 0;
	int          check_count = 0;

	always #5 mclk = ~mclk;

	// Wire levels: released pins show inverse, host drives bits 4..2
	assign dbi = (dboe & dbo) | (~dboe & {~dbo[15:5], cfg, ~dbo[1:0]});
	assign sclk = sclk_oe ? sclk_o : sclk_h;
	assign sdo_w = sdo_oe ? sdo : ~sdo;

	ops_port ops_port_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.byte_order_select(bo), .output_code_format_select(fmt),
		.serial_parallel_select(sp), .read_during_convert_select(rdsel),
		.convert_busy(busy), .result_data(rd), .result_valid(rv),
		.result_ready(rr), .data_bus_i(dbi), .data_bus_o(dbo),
		.data_bus_oe(dboe), .cs_n(cs_n), .serial_data_clock_i(sclk),
		.serial_data_clock_o(sclk_o), .serial_data_clock_oe(sclk_oe),
		.serial_data_out(sdo), .serial_data_out_oe(sdo_oe));

	ops_host ops_host_inst (.mclk(mclk), .cs_n(cs_n), .slave(cfg[2]),
		.sclk(sclk), .sdo(sdo_w), .sclk_h(sclk_h), .word(rx),
		.nbits(nb), .period(per));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// Reference model of the code format
	function automatic logic [15:0] fmtw(input logic [15:0] w);
		return fmt ? w : {~w[15], w[14:0]};
	endfunction : fmtw

	task automatic push(input int v);
		int i;
		@(negedge mclk);
		rd = v[15:0];
		rv = 1;
		for (i = 0; i < 50 && rr !== 1'b1; i++)
			@(negedge mclk);
		@(negedge mclk);
		rv = 0;
		exp_q.push_back(fmtw(v[15:0]));
	endtask : push

	task automatic rx_word(input int p);
		int i;
		@(negedge mclk);
		cs_n = 0;
		for (i = 0; i < 2000 && nb !== 5'd16; i++)
			@(negedge mclk);
		check(rx, exp_q.pop_front());
		check(per, p[15:0]);
		check({sclk_oe, sdo_oe}, {!cfg[2], 1'b1});
		cs_n = 1;
	endtask : rx_word

	initial begin
		#400000;
		num_errors++;
		summarize();
	end

	initial begin
		int i, k;
		logic [15:0] w;
		void'($urandom(9));
		{bo, fmt, sp, rdsel, busy, rv, rd, cfg} = '0;
		ce = 1;
		cs_n = 1;
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1;
		repeat (4) @(negedge mclk);
		for (i = 0; i < 16; i++) begin
			{fmt, bo} = i[1:0];
			push((i == 5) ? 32'h8000 : $urandom);
			repeat (3) @(negedge mclk);
			w = exp_q.pop_front();
			check(dbo, bo ? {w[7:0], w[15:8]} : w);
			check(dboe, 16'hFFFF);
		end
		// Clock enable low freezes the bus while byte order flips
		ce = 0;
		bo = 0;
		repeat (3) @(negedge mclk);
		check(dbo, {w[7:0], w[15:8]});
		ce = 1;
		repeat (2) @(negedge mclk);
		check(dbo, w);
		sp = 1;
		fmt = 0;
		cfg = 3'b100;
		repeat (3) @(negedge mclk);
		check(dboe, 16'h0003);
		check(dbo, {14'h0, w[1:0]});
		// Host stalls with chip select off until the buffer refuses
		push($urandom);
		push($urandom);
		@(negedge mclk);
		check({15'h0, rr}, 16'h0000);
		rx_word(6);
		rx_word(6);
		check({15'h0, rr}, 16'h0001);
		// Master read after convert over every divider setting
		for (k = 0; k < 4; k++) begin
			cfg = {1'b0, k[1:0]};
			busy = 1;
			push($urandom);
			cs_n = 0;
			repeat (30) @(negedge mclk);
			check({11'h0, nb}, 16'h0000);
			busy = 0;
			rx_word(3 << k);
		end
		// Read during convert ignores busy and the divider
		rdsel = 1;
		busy = 1;
		cfg = 3'b011;
		push($urandom);
		rx_word(3);
		// Chip select high mid-word drops that word
		rdsel = 0;
		busy = 0;
		cfg = 3'b000;
		push($urandom);
		push($urandom);
		cs_n = 0;
		for (i = 0; i < 200 && nb !== 5'd4; i++)
			@(negedge mclk);
		cs_n = 1;
		void'(exp_q.pop_front());
		repeat (4) @(negedge mclk);
		rx_word(3);
		// Slave mode shifts on the host clock regardless of busy
		fmt = 1;
		busy = 1;
		cfg = 3'b100;
		push($urandom);
		rx_word(6);
		summarize();
	end
endmodule : adc_output_port_mode_select_test
`default_nettype wire

/* File: testbench/ops_host.sv */
// Host-side model: slave serial clock source and result receiver
`timescale 1ns/10ps
`default_nettype none
module ops_host (
	input  wire  logic        mclk,
	input  wire  logic        cs_n,
	input  wire  logic        slave,
	input  wire  logic        sclk,
	input  wire  logic        sdo,
	output logic              sclk_h,
	output logic [15:0]       word,
	output logic [4:0]        nbits,
	output logic [15:0]       period
);
	logic [1:0]  ph;
	logic        prev;
	logic [15:0] cnt;

	// Gated host clock
	// Stands low outside frames, so no stray edge reaches the port
	always @(posedge mclk) begin
		if (!slave || cs_n) begin
			ph <= 2'd0;
			sclk_h <= 1'b0;
		end else if (sclk_h || nbits < 5'd16) begin
			ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
			if (ph == 2'd2)
				sclk_h <= ~sclk_h;
		end
	end

	always @(posedge mclk) begin
		prev <= sclk;
		if (cs_n)
			nbits <= 5'd0;
		else if (sclk && !prev) begin
			word <= {word[14:0], sdo};
			nbits <= nbits + 5'd1;
			period <= cnt;
			cnt <= 16'd1;
		end else
			cnt <= cnt + 16'd1;
	end
endmodule : ops_host
`default_nettype wire
